// File: core/sample_fifo.v
// Purpose: sample word FIFO with optional overwrite of the oldest entry
// Assumes: single clock, push and pop in the same cycle allowed
// Notes:   with overwrite set a push into a full buffer drops the oldest word
`timescale 1ns/10ps
module sample_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_i,
  input  wire             rst_n_i,
  input  wire             overwrite_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  output wire [AW:0]      level_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  wire            full;
  wire            push;
  wire            pop;
  wire            drop;

  assign full        = (count_q == DEPTH[AW:0]);
  assign in_ready_o  = ~full | overwrite_i;
  assign out_valid_o = (count_q != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr_q];
  assign level_o     = count_q;
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  // full and no pop: the oldest word makes room for the new one
  assign drop        = push & full & ~pop;

  always @(posedge clk_i)
  begin
    if (push)
      mem[wr_ptr_q] <= in_data_i;
  end

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      if (pop | drop)
        rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      if (push & ~pop & ~full)
        count_q <= count_q + {{AW{1'b0}}, 1'b1};
      else if (pop & ~push)
        count_q <= count_q - {{AW{1'b0}}, 1'b1};
    end
  end
endmodule // sample_fifo

// File: core/slot_fifo_consts.vh
// Purpose: shared offsets, field positions and reset values for the slot FIFO control
// Assumes: 8-bit register addresses, 16-bit register data
// Notes:   definitions only
`ifndef SLOT_FIFO_CONSTS_VH
`define SLOT_FIFO_CONSTS_VH

// register offsets
`define MODE_ADDR          8'h10
`define SLOT_CFG_ADDR      8'h11
`define AVG_FACTOR_ADDR    8'h15

// reset values
`define MODE_RESET         16'h0000
`define SLOT_CFG_RESET     16'h1000
`define AVG_FACTOR_RESET   16'h0000

// writable bit masks, the rest reads as zero
`define MODE_MASK          16'h0003
`define SLOT_CFG_MASK      16'h31fd
`define AVG_FACTOR_MASK    16'h0770

// operating mode encodings
`define MODE_STANDBY       2'h0
`define MODE_PROGRAM       2'h1
`define MODE_NORMAL        2'h2

// slot configuration fields
`define CFG_READBACK_BIT   13
`define CFG_GUARD_BIT      12
`define CFG_B_FMT_HI       8
`define CFG_B_FMT_LO       6
`define CFG_B_EN_BIT       5
`define CFG_A_FMT_HI       4
`define CFG_A_FMT_LO       2
`define CFG_A_EN_BIT       0

// averaging factor fields
`define AVG_B_HI           10
`define AVG_B_LO           8
`define AVG_A_HI           6
`define AVG_A_LO           4

// store format encodings
`define FMT_NONE           3'h0
`define FMT_SUM16          3'h1
`define FMT_SUM32          3'h2
`define FMT_CH16           3'h4
`define FMT_CH32           3'h6

// sample buffer geometry
`define FIFO_WIDTH         16
`define FIFO_DEPTH         8
`define FIFO_AW            3

`endif

// File: core/slot_fifo_format_control.v
// Purpose: slot enables, store formats and overrun policy for the sample FIFO
// Assumes: register port and slot sample events come from logic on CORE_CLK_I
// Notes:   each slot event carries four 32-bit channel block sums of N samples
//
// What this block does
// - two-bit operating mode field in low bits of mode register selects operating state
// - slot config bit 13 picks block sum or block average readback
// - bit 12 clear: FIFO wraps, newest samples overwrite oldest data
// - bit 12 set, its reset value: store new sample only if all its words fit
// - slot B format bits 8:6: none, 16-bit sum, 32-bit sum
// - slot B format 4 stores four 16-bit channels, 6 four 32-bit channels
// - slot B stored only if averaging factors match or slot A format is none
// - bit 5 enables slot B; slot B inactive while clear
// - slot A format bits 4:2: none, 16-bit sum, 32-bit sum
// - slot A format 4 stores four 16-bit channels, 6 four 32-bit channels
// - bit 0 enables slot A, reset value zero
`timescale 1ns/10ps
`include "slot_fifo_consts.vh"
module slot_fifo_format_control (
  input  wire         CORE_CLK_I,
  input  wire         RST_N_I,
  input  wire [7:0]   REG_ADDR_I,
  input  wire         REG_WR_I,
  input  wire [15:0]  REG_WDATA_I,
  input  wire         REG_RD_I,
  output reg  [15:0]  REG_RDATA_O,
  input  wire         SLOT_A_DONE_I,
  input  wire [127:0] SLOT_A_DATA_I,
  input  wire         SLOT_B_DONE_I,
  input  wire [127:0] SLOT_B_DATA_I,
  output reg  [15:0]  FIFO_DATA_O,
  output reg          FIFO_VALID_O,
  input  wire         FIFO_READY_I,
  output reg  [3:0]   FIFO_LEVEL_O,
  output reg          SAMPLE_DROP_O,
  output reg  [1:0]   OPER_MODE_O,
  output reg          SLOT_A_ACTIVE_O,
  output reg          SLOT_B_ACTIVE_O
);
  reg  [15:0]  mode_q;
  reg  [15:0]  cfg_q;
  reg  [15:0]  avg_q;
  reg          pend_a_q;
  reg          pend_b_q;
  reg  [127:0] hold_a_q;
  reg  [127:0] hold_b_q;
  reg  [127:0] words_q;
  reg  [3:0]   left_q;
  reg          pend_a_d;
  reg          pend_b_d;
  reg  [127:0] words_d;
  reg  [3:0]   left_d;
  reg          drop_d;
  reg          take_a;
  reg          take_b;
  reg  [2:0]   sel_fmt;
  reg  [127:0] sel_data;
  reg  [2:0]   sel_shift;
  reg  [3:0]   sel_need;

  wire [1:0]   oper_mode;
  wire         normal;
  wire         readback_avg;
  wire         overflow_guard;
  wire [2:0]   first_slot_store_format;
  wire [2:0]   second_slot_store_format;
  wire         first_slot_enable;
  wire         second_slot_enable;
  wire [2:0]   avg_a;
  wire [2:0]   avg_b;
  wire         b_allowed;
  wire         event_a;
  wire         event_b;
  wire         fifo_in_ready;
  wire         fifo_in_valid;
  wire         fifo_out_valid;
  wire         fifo_out_ready;
  wire [15:0]  fifo_out_data;
  wire [3:0]   fifo_level;
  wire [3:0]   fifo_free;

  assign oper_mode                = mode_q[1:0];
  assign normal                   = (oper_mode == `MODE_NORMAL);
  assign readback_avg             = cfg_q[`CFG_READBACK_BIT];
  assign overflow_guard           = cfg_q[`CFG_GUARD_BIT];
  assign second_slot_store_format = cfg_q[`CFG_B_FMT_HI:`CFG_B_FMT_LO];
  assign first_slot_store_format  = cfg_q[`CFG_A_FMT_HI:`CFG_A_FMT_LO];
  assign second_slot_enable       = cfg_q[`CFG_B_EN_BIT];
  assign first_slot_enable        = cfg_q[`CFG_A_EN_BIT];
  assign avg_a                    = avg_q[`AVG_A_HI:`AVG_A_LO];
  assign avg_b                    = avg_q[`AVG_B_HI:`AVG_B_LO];

  // slot B may only share the FIFO when its block timing matches slot A
  assign b_allowed = (first_slot_store_format == `FMT_NONE) | (avg_a == avg_b);

  // samples are only accepted while sampling; a slot that stores nothing is ignored
  assign event_a = SLOT_A_DONE_I & normal & first_slot_enable
                   & (words_for(first_slot_store_format) != 4'h0);
  assign event_b = SLOT_B_DONE_I & normal & second_slot_enable
                   & b_allowed
                   & (words_for(second_slot_store_format) != 4'h0);

  // words per sample; reserved codes store nothing
  function [3:0] words_for;
    input [2:0] fmt;
    begin
      case (fmt)
        `FMT_SUM16: words_for = 4'h1;
        `FMT_SUM32: words_for = 4'h2;
        `FMT_CH16:  words_for = 4'h4;
        `FMT_CH32:  words_for = 4'h8;
        default:    words_for = 4'h0;
      endcase
    end
  endfunction

  function [15:0] sat16;
    input [31:0] v;
    begin
      sat16 = (v[31:16] != 16'h0000) ? 16'hffff : v[15:0];
    end
  endfunction

  // word list in push order, first word in the low lane; 32-bit values high half first
  function [127:0] pack_words;
    input [2:0]   fmt;
    input [127:0] ch;
    input [2:0]   sh;
    reg   [31:0]  c0;
    reg   [31:0]  c1;
    reg   [31:0]  c2;
    reg   [31:0]  c3;
    reg   [33:0]  sum;
    reg   [31:0]  s32;
    begin
      c0  = ch[31:0] >> sh;
      c1  = ch[63:32] >> sh;
      c2  = ch[95:64] >> sh;
      c3  = ch[127:96] >> sh;
      sum = {2'b00, c0} + {2'b00, c1} + {2'b00, c2} + {2'b00, c3};
      s32 = (sum[33:32] != 2'b00) ? 32'hffffffff : sum[31:0];
      pack_words = 128'h0;
      case (fmt)
        `FMT_SUM16: pack_words[15:0] = sat16(s32);
        `FMT_SUM32: pack_words[31:0] = {s32[15:0], s32[31:16]};
        `FMT_CH16:  pack_words[63:0] = {sat16(c3), sat16(c2), sat16(c1), sat16(c0)};
        `FMT_CH32:  pack_words = {c3[15:0], c3[31:16], c2[15:0], c2[31:16],
                                  c1[15:0], c1[31:16], c0[15:0], c0[31:16]};
        default:    pack_words = 128'h0;
      endcase
    end
  endfunction

  assign fifo_in_valid  = (left_q != 4'h0);
  assign fifo_free      = 4'h8 - fifo_level;
  assign fifo_out_ready = ~FIFO_VALID_O | FIFO_READY_I;

  // register writes; reserved bits are not stored and read as zero
  always @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      mode_q <= `MODE_RESET;
      cfg_q  <= `SLOT_CFG_RESET;
      avg_q  <= `AVG_FACTOR_RESET;
    end
    else if (REG_WR_I)
    begin
      case (REG_ADDR_I)
        `MODE_ADDR:       mode_q <= REG_WDATA_I & `MODE_MASK;
        `SLOT_CFG_ADDR:   cfg_q  <= REG_WDATA_I & `SLOT_CFG_MASK;
        `AVG_FACTOR_ADDR: avg_q  <= REG_WDATA_I & `AVG_FACTOR_MASK;
        default:          ;
      endcase
    end
  end

  // registered readback, one cycle after the strobe; unmapped reads return zero
  always @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      REG_RDATA_O <= 16'h0000;
    else if (REG_RD_I)
    begin
      case (REG_ADDR_I)
        `MODE_ADDR:       REG_RDATA_O <= mode_q;
        `SLOT_CFG_ADDR:   REG_RDATA_O <= cfg_q;
        `AVG_FACTOR_ADDR: REG_RDATA_O <= avg_q;
        default:          REG_RDATA_O <= 16'h0000;
      endcase
    end
  end

  // pick the next sample: slot A first when both wait
  always @*
  begin
    take_a    = 1'b0;
    take_b    = 1'b0;
    sel_fmt   = `FMT_NONE;
    sel_data  = 128'h0;
    sel_shift = 3'h0;
    if (left_q == 4'h0)
    begin
      if (pend_a_q)
      begin
        take_a    = 1'b1;
        sel_fmt   = first_slot_store_format;
        sel_data  = hold_a_q;
        sel_shift = readback_avg ? avg_a : 3'h0;
      end
      else if (pend_b_q)
      begin
        take_b    = 1'b1;
        sel_fmt   = second_slot_store_format;
        sel_data  = hold_b_q;
        sel_shift = readback_avg ? avg_b : 3'h0;
      end
    end
    sel_need = words_for(sel_fmt);
  end

  always @*
  begin
    // a new event in the cycle its pending flag is taken stays pending
    pend_a_d = (pend_a_q & ~take_a) | event_a;
    pend_b_d = (pend_b_q & ~take_b) | event_b;
    words_d  = words_q;
    left_d   = left_q;
    drop_d   = 1'b0;
    if (fifo_in_valid & fifo_in_ready)
    begin
      words_d = {16'h0000, words_q[127:16]};
      left_d  = left_q - 4'h1;
    end
    else if (take_a | take_b)
    begin
      // guarded: a sample that does not fit whole is dropped, never split
      if (overflow_guard & (sel_need > fifo_free))
        drop_d = 1'b1;
      else
      begin
        words_d = pack_words(sel_fmt, sel_data, sel_shift);
        left_d  = sel_need;
      end
    end
  end

  always @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      pend_a_q <= 1'b0;
      pend_b_q <= 1'b0;
      hold_a_q <= 128'h0;
      hold_b_q <= 128'h0;
      words_q  <= 128'h0;
      left_q   <= 4'h0;
    end
    else
    begin
      pend_a_q <= pend_a_d;
      pend_b_q <= pend_b_d;
      words_q  <= words_d;
      left_q   <= left_d;
      if (event_a)
        hold_a_q <= SLOT_A_DATA_I;
      if (event_b)
        hold_b_q <= SLOT_B_DATA_I;
    end
  end

  // guard clear lets the buffer overwrite its oldest word instead of stalling
  sample_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .clk_i       (CORE_CLK_I),
    .rst_n_i     (RST_N_I),
    .overwrite_i (~overflow_guard),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (words_q[15:0]),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data),
    .level_o     (fifo_level)
  );

  // output stage keeps every port on a flip-flop; costs one cycle of latency
  always @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      FIFO_DATA_O     <= 16'h0000;
      FIFO_VALID_O    <= 1'b0;
      FIFO_LEVEL_O    <= 4'h0;
      SAMPLE_DROP_O   <= 1'b0;
      OPER_MODE_O     <= `MODE_STANDBY;
      SLOT_A_ACTIVE_O <= 1'b0;
      SLOT_B_ACTIVE_O <= 1'b0;
    end
    else
    begin
      if (fifo_out_ready)
      begin
        FIFO_VALID_O <= fifo_out_valid;
        FIFO_DATA_O  <= fifo_out_valid ? fifo_out_data : FIFO_DATA_O;
      end
      FIFO_LEVEL_O    <= fifo_level;
      SAMPLE_DROP_O   <= drop_d;
      OPER_MODE_O     <= oper_mode;
      SLOT_A_ACTIVE_O <= normal & first_slot_enable;
      SLOT_B_ACTIVE_O <= normal & second_slot_enable;
    end
  end
endmodule // slot_fifo_format_control

// File: test/host_side_model.sv
// Purpose: word consumer standing for the host side
// Assumes: ready changes on the falling edge only
// Notes:   slow halves the take rate, stall holds ready low
`timescale 1ns/10ps
module host_side_model (
  input wire        clk_i,
  input wire        slow_i,
  input wire        stall_i,
  input wire        valid_i,
  input wire [15:0] data_i,
  output logic      ready_o
);
  logic [15:0] got[$];
  logic        ph;
  initial ready_o = 1'b0;
  initial ph = 1'b0;
  always @(negedge clk_i)
  begin
    ph = !ph;
    ready_o = !stall_i && (!slow_i || ph);
  end
  always @(posedge clk_i)
    if (valid_i && ready_o)
      got.push_back(data_i);
endmodule // host_side_model

// File: test/slot_fifo_format_control_checker.sv
// Purpose: port level checks for the slot fifo control
// Assumes: single clock, async active low reset
// Notes:   attached by bind from the bench
`timescale 1ns/10ps
module slot_fifo_format_control_checker (
  input wire        CORE_CLK_I,
  input wire        RST_N_I,
  input wire [7:0]  REG_ADDR_I,
  input wire        REG_WR_I,
  input wire [15:0] REG_WDATA_I,
  input wire        REG_RD_I,
  input wire [15:0] REG_RDATA_O,
  input wire [15:0] FIFO_DATA_O,
  input wire        FIFO_VALID_O,
  input wire        FIFO_READY_I,
  input wire [3:0]  FIFO_LEVEL_O,
  input wire        SAMPLE_DROP_O,
  input wire [1:0]  OPER_MODE_O,
  input wire        SLOT_A_ACTIVE_O,
  input wire        SLOT_B_ACTIVE_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // shadow of the guard and enable bits, tracked from the register writes
  logic guard_q;
  logic en_a_q;
  logic en_b_q;
  always @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      {guard_q, en_a_q, en_b_q} <= 3'b100;
    else if (REG_WR_I && REG_ADDR_I == 8'h11)
      {guard_q, en_a_q, en_b_q} <= {REG_WDATA_I[12], REG_WDATA_I[0], REG_WDATA_I[5]};
  end
  property p_drop_guard;
    SAMPLE_DROP_O |-> $past(guard_q);
  endproperty
  a_drop_guard: assert property (p_drop_guard)
    else $error("sample dropped while overwrite selected");
  property p_a_en;
    SLOT_A_ACTIVE_O == (OPER_MODE_O == 2'h2 && $past(en_a_q));
  endproperty
  a_a_en: assert property (p_a_en)
    else $error("slot a active differs from enable and mode");
  property p_b_en;
    SLOT_B_ACTIVE_O == (OPER_MODE_O == 2'h2 && $past(en_b_q));
  endproperty
  a_b_en: assert property (p_b_en)
    else $error("slot b active differs from enable and mode");
  property p_rd_hold;
    !REG_RD_I |=> $stable(REG_RDATA_O);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without a read");
  property p_mode_rd;
    REG_RD_I && !REG_WR_I && REG_ADDR_I == 8'h10 |=> REG_RDATA_O == {14'h0000, OPER_MODE_O};
  endproperty
  a_mode_rd: assert property (p_mode_rd)
    else $error("mode readback differs from mode output");
  property p_cfg_rd;
    REG_RD_I && REG_ADDR_I == 8'h11 |=> (REG_RDATA_O & 16'hce02) == 16'h0000;
  endproperty
  a_cfg_rd: assert property (p_cfg_rd)
    else $error("reserved config bits read nonzero");
  property p_valid_hold;
    FIFO_VALID_O && !FIFO_READY_I |=> FIFO_VALID_O && $stable(FIFO_DATA_O);
  endproperty
  a_valid_hold: assert property (p_valid_hold)
    else $error("output word lost while stalled");
  property p_level_max;
    FIFO_LEVEL_O <= 4'h8;
  endproperty
  a_level_max: assert property (p_level_max)
    else $error("fifo level beyond depth");
  property p_a_act;
    SLOT_A_ACTIVE_O |-> OPER_MODE_O == 2'h2;
  endproperty
  a_a_act: assert property (p_a_act)
    else $error("slot a active outside normal mode");
  property p_b_act;
    SLOT_B_ACTIVE_O |-> OPER_MODE_O == 2'h2;
  endproperty
  a_b_act: assert property (p_b_act)
    else $error("slot b active outside normal mode");
  property p_en_off;
    REG_WR_I && REG_ADDR_I == 8'h11 && !REG_WDATA_I[5] |-> ##2 !SLOT_B_ACTIVE_O;
  endproperty
  a_en_off: assert property (p_en_off)
    else $error("slot b still active after disable");
  c_drop: cover property (SAMPLE_DROP_O);
  c_take: cover property (FIFO_VALID_O && FIFO_READY_I);
  c_full: cover property (FIFO_LEVEL_O == 4'h8);
endmodule // slot_fifo_format_control_checker

// File: test/slot_fifo_format_control_tb.sv
// Purpose: self-checking bench for the slot fifo control
// Assumes: inputs move on the falling edge
// Notes:   words are collected by the host side model
`timescale 1ns/10ps
`include "slot_fifo_consts.vh"
module slot_fifo_format_control_tb;
  logic         clk, rst_n, wr, rd, a_done, b_done, slow, stall;
  logic [7:0]   addr;
  logic [15:0]  wdata;
  logic [127:0] a_data, b_data;
  wire  [15:0]  rdata, fdata;
  wire          fvalid, fready, drop, a_act, b_act;
  wire  [3:0]   level;
  wire  [1:0]   mode;
  int           n_fail, compares, n_drop;
  logic [15:0]  ev[$];
  logic [127:0] d1 = {32'h0003_0008, 32'h0000_0204, 32'h0000_0100, 32'h0000_0011};
  logic [2:0]   fl[4] = '{`FMT_SUM16, `FMT_SUM32, `FMT_CH16, `FMT_CH32};
  slot_fifo_format_control dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr),
    .REG_WR_I(wr), .REG_WDATA_I(wdata), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .SLOT_A_DONE_I(a_done), .SLOT_A_DATA_I(a_data), .SLOT_B_DONE_I(b_done),
    .SLOT_B_DATA_I(b_data), .FIFO_DATA_O(fdata), .FIFO_VALID_O(fvalid),
    .FIFO_READY_I(fready), .FIFO_LEVEL_O(level), .SAMPLE_DROP_O(drop),
    .OPER_MODE_O(mode), .SLOT_A_ACTIVE_O(a_act), .SLOT_B_ACTIVE_O(b_act));
  host_side_model u (.clk_i(clk), .slow_i(slow), .stall_i(stall), .valid_i(fvalid),
    .data_i(fdata), .ready_o(fready));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
    if (drop)
      n_drop <= n_drop + 1;
  task automatic test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [15:0] e);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk(rdata, e);
  endtask
  task automatic send(input logic b, input logic [127:0] d);
    @(negedge clk);
    {a_data, b_data, a_done, b_done} = {d, d, !b, b};
    @(negedge clk);
    {a_done, b_done} = 2'b00;
  endtask
  // saturating pack, each channel shifted first when averaging
  function automatic void mk(input logic [2:0] f, input logic [127:0] d, input int sh);
    logic [63:0] s;
    logic [31:0] c;
    s = 64'h0;
    ev.delete();
    for (int k = 0; k < 4; k++)
      s += d[32*k+:32] >> sh;
    if (s > 64'hffffffff) s = 64'hffffffff;
    if (f == `FMT_SUM16) ev.push_back(s > 64'hffff ? 16'hffff : s[15:0]);
    if (f == `FMT_SUM32) ev = '{s[31:16], s[15:0]};
    for (int k = 0; k < 4; k++)
    begin
      c = d[32*k+:32] >> sh;
      if (f == `FMT_CH16) ev.push_back(c > 32'hffff ? 16'hffff : c[15:0]);
      if (f == `FMT_CH32) ev = {ev, c[31:16], c[15:0]};
    end
  endfunction
  task automatic run(input logic b, input logic [127:0] d);
    u.got.delete();
    send(b, d);
    for (int i = 0; i < 80 && u.got.size() < ev.size(); i++)
      @(negedge clk);
    repeat (10) @(negedge clk);
    chk(16'(u.got.size()), 16'(ev.size()));
    foreach (ev[k])
      chk(u.got[k], ev[k]);
  endtask
  task automatic t_regs;
    rreg(`MODE_ADDR, 16'h0000);
    rreg(`SLOT_CFG_ADDR, 16'h1000);
    rreg(8'h20, 16'h0000);
    wreg(`AVG_FACTOR_ADDR, 16'hffff);
    rreg(`AVG_FACTOR_ADDR, 16'h0770);
    wreg(`AVG_FACTOR_ADDR, 16'h0000);
    wreg(`SLOT_CFG_ADDR, 16'hffff);
    rreg(`SLOT_CFG_ADDR, 16'h31fd);
    wreg(`MODE_ADDR, 16'hfffe);
    rreg(`MODE_ADDR, 16'h0002);
  endtask
  task automatic t_formats;
    foreach (fl[i])
    begin
      wreg(`SLOT_CFG_ADDR, 16'h1001 | (16'(fl[i]) << 2));
      mk(fl[i], d1, 0);
      run(1'b0, d1);
      slow = 1'b1;
      wreg(`SLOT_CFG_ADDR, 16'h1020 | (16'(fl[i]) << 6));
      run(1'b1, d1);
      slow = 1'b0;
    end
  endtask
  task automatic t_gating;
    ev.delete();
    wreg(`SLOT_CFG_ADDR, 16'h1025);
    wreg(`MODE_ADDR, 16'h0001);
    run(1'b0, d1);
    chk({14'h0, mode}, 16'h0001);
    chk({14'h0, a_act, b_act}, 16'h0000);
    wreg(`MODE_ADDR, 16'h0002);
    wreg(`SLOT_CFG_ADDR, 16'h1001);
    run(1'b0, d1);
    wreg(`SLOT_CFG_ADDR, 16'h100d);
    run(1'b0, d1);
    wreg(`SLOT_CFG_ADDR, 16'h10e0);
    run(1'b1, d1);
    wreg(`SLOT_CFG_ADDR, 16'h1044);
    run(1'b0, d1);
    run(1'b1, d1);
    chk({14'h0, a_act, b_act}, 16'h0000);
    wreg(`AVG_FACTOR_ADDR, 16'h0210);
    wreg(`SLOT_CFG_ADDR, 16'h1065);
    run(1'b1, d1);
    wreg(`AVG_FACTOR_ADDR, 16'h0110);
    mk(`FMT_SUM16, d1, 0);
    run(1'b1, d1);
    chk({14'h0, a_act, b_act}, 16'h0003);
  endtask
  task automatic t_average;
    wreg(`AVG_FACTOR_ADDR, 16'h0020);
    wreg(`SLOT_CFG_ADDR, 16'h3011);
    mk(`FMT_CH16, d1, 2);
    run(1'b0, d1);
  endtask
  task automatic t_guard;
    logic [127:0] d2;
    logic [15:0]  w0;
    int           n0;
    d2 = {d1[63:0], d1[127:64]};
    wreg(`SLOT_CFG_ADDR, 16'h1019);
    stall = 1'b1;
    n0 = n_drop;
    mk(`FMT_CH32, d1, 0);
    send(1'b0, d1);
    repeat (20) @(negedge clk);
    // one word sits in the output stage, the other seven in the buffer
    chk({12'h000, level}, 16'h0007);
    stall = 1'b0;
    run(1'b0, d2);
    chk(16'(n_drop - n0), 16'h0001);
    wreg(`SLOT_CFG_ADDR, 16'h0019);
    stall = 1'b1;
    n0 = n_drop;
    send(1'b0, d1);
    repeat (20) @(negedge clk);
    // the output stage keeps the first word, the buffer ends with all of d2
    w0 = ev[0];
    mk(`FMT_CH32, d2, 0);
    ev = {w0, ev};
    u.got.delete();
    send(1'b0, d2);
    repeat (20) @(negedge clk);
    chk({12'h000, level}, 16'h0008);
    stall = 1'b0;
    repeat (30) @(negedge clk);
    chk(16'(u.got.size()), 16'd9);
    for (int k = 0; k < 9; k++)
      chk(u.got[k], ev[k]);
    chk(16'(n_drop - n0), 16'h0000);
  endtask
  task automatic t_reset;
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    chk({fvalid, drop, a_act, b_act, level, 6'h00, mode}, 16'h0000);
    rst_n = 1'b1;
    rreg(`MODE_ADDR, 16'h0000);
    rreg(`SLOT_CFG_ADDR, 16'h1000);
    rreg(`AVG_FACTOR_ADDR, 16'h0000);
  endtask
  initial
  begin
    {rst_n, wr, rd, a_done, b_done, slow, stall} = 7'h00;
    {addr, wdata, a_data, b_data} = 0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_regs();
    t_formats();
    t_gating();
    t_average();
    t_guard();
    t_reset();
    test_done();
  end
  initial
  begin
    #(25 * 20000);
    n_fail++;
    test_done();
  end
endmodule // slot_fifo_format_control_tb
bind slot_fifo_format_control slot_fifo_format_control_checker chk_i (.*);
